// ===== core/dpc_pkg.sv
// Purpose: constants for the dual-port RAM port host controller
// Assumes: 100 MHz REF_CLK, fastest speed grade of the RAM
// Notes: cycle counts derived from ns figures
package dpc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int WRITE_PULSE_NS = 20;
  localparam int TURN_OFF_NS = 15;
  localparam int DATA_TO_WRITE_END_NS = 15;
  localparam int CS_ACCESS_NS = 25;
  localparam int LANE_ACCESS_NS = 25;
  localparam int OE_ACCESS_NS = 15;
  localparam int COLLISION_RELEASE_TO_DATA_NS = 35;
  localparam int FLAG_ACCESS_NS = 35;
  localparam int FLAG_PULSE_NS = 15;
  localparam int FLAG_WRITE_TO_READ_NS = 5;
  localparam int READ_CYCLE_NS = 25;
  // least times round up
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_OE_CYC =
    (TURN_OFF_NS + DATA_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_SETUP_CYC = (DATA_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAG_PULSE_CYC = (FLAG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAG_GAP_CYC = (FLAG_WRITE_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARRAY_READ_NS = (CS_ACCESS_NS > LANE_ACCESS_NS) ? CS_ACCESS_NS : LANE_ACCESS_NS;
  // waiting for data is a least time for the host, round up plus sample margin
  localparam int ARRAY_READ_CYC = (ARRAY_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int COLL_READ_CYC =
    (COLLISION_RELEASE_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int FLAG_READ_CYC = (FLAG_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int CNT_W = 4;
endpackage

// ===== core/dpc_host.sv
// Purpose: host-side sequencer driving one port of a dual-port static RAM
// Assumes: RAM pins sampled synchronously to REF_CLK
// Notes: one request at a time; REQ_READY high when idle
`timescale 1ns/1ns
module dpc_host
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic REQ_FLAG,
  input wire logic [dpc_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic [dpc_pkg::DATA_W-1:0] REQ_WDATA,
  input wire logic [1:0] REQ_LANES,
  input wire logic COLLISION_N,
  output logic RSP_VALID,
  output logic [dpc_pkg::DATA_W-1:0] RSP_RDATA,
  output logic CHIP_SEL_N,
  output logic FLAG_SELECT_N,
  output logic RW_N,
  output logic OUT_EN_N,
  output logic HIGH_LANE_SEL_N,
  output logic LOW_LANE_SEL_N,
  output logic [dpc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [dpc_pkg::DATA_W-1:0] DATA_I,
  output logic [dpc_pkg::DATA_W-1:0] DATA_O,
  output logic DATA_OE
);
  // ****************************************************
  // state
  // ****************************************************
  typedef enum logic [2:0] {IDLE, SETUP, WPULSE, RWAIT, RDONE, GAP} dpc_state_t;
  dpc_state_t state, next_state;
  logic [dpc_pkg::CNT_W-1:0] cnt, next_cnt;
  logic is_wr, next_is_wr, is_flag, next_is_flag;
  logic cs_n, next_cs_n, fs_n, next_fs_n, rw_n, next_rw_n, oe_n, next_oe_n;
  logic [1:0] lanes_n, next_lanes_n;
  logic [dpc_pkg::ADDR_W-1:0] addr, next_addr;
  logic [dpc_pkg::DATA_W-1:0] wdata, next_wdata, rdata, next_rdata;
  logic doe, next_doe, rsp, next_rsp;
  logic coll_seen, next_coll_seen;

  // ****************************************************
  // sequencer
  // ****************************************************
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_is_wr = is_wr;
    next_is_flag = is_flag;
    next_cs_n = cs_n;
    next_fs_n = fs_n;
    next_rw_n = rw_n;
    next_oe_n = oe_n;
    next_lanes_n = lanes_n;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_doe = doe;
    next_rsp = 1'b0;
    next_coll_seen = coll_seen;
    case (state)
      IDLE:
      begin
        if (REQ_VALID)
        begin
          // address moves with the lane selects, while chip and flag selects are high
          next_addr = REQ_ADDR;
          next_wdata = REQ_WDATA;
          next_is_wr = REQ_WRITE;
          next_is_flag = REQ_FLAG;
          next_lanes_n = ~REQ_LANES;
          next_oe_n = 1'b1;
          next_coll_seen = 1'b0;
          next_state = SETUP;
        end
      end
      SETUP:
      begin
        // selection set one cycle after the address, held to write end
        next_cs_n = is_flag;
        next_fs_n = ~is_flag;
        if (is_wr)
        begin
          // strobe falls with select; oe stays high so RAM never drives
          next_rw_n = 1'b0;
          next_doe = 1'b1;
          next_cnt = is_flag ? dpc_pkg::CNT_W'(dpc_pkg::FLAG_PULSE_CYC)
                             : dpc_pkg::CNT_W'(dpc_pkg::WRITE_CYC);
          next_state = WPULSE;
        end
        else
        begin
          next_oe_n = 1'b0;
          next_cnt = is_flag ? dpc_pkg::CNT_W'(dpc_pkg::FLAG_READ_CYC)
                             : dpc_pkg::CNT_W'(dpc_pkg::ARRAY_READ_CYC);
          next_state = RWAIT;
        end
      end
      WPULSE:
      begin
        // oe high all through, so the plain pulse width is enough
        if (cnt > dpc_pkg::CNT_W'(1))
          next_cnt = cnt - dpc_pkg::CNT_W'(1);
        else
        begin
          // strobe and select rise together; data held one more cycle
          next_rw_n = 1'b1;
          next_cs_n = 1'b1;
          next_fs_n = 1'b1;
          next_cnt = dpc_pkg::CNT_W'(dpc_pkg::FLAG_GAP_CYC);
          next_state = GAP;
        end
      end
      RWAIT:
      begin
        // busy seen low means a same-address write on the far port
        // one restart per read keeps the wait bounded
        if (!COLLISION_N && !is_flag && !coll_seen)
        begin
          next_coll_seen = 1'b1;
          next_cnt = dpc_pkg::CNT_W'(dpc_pkg::COLL_READ_CYC);
        end
        else if (cnt > dpc_pkg::CNT_W'(1))
          next_cnt = cnt - dpc_pkg::CNT_W'(1);
        else
        begin
          next_rdata = DATA_I;
          next_rsp = 1'b1;
          next_cs_n = 1'b1;
          next_fs_n = 1'b1;
          next_oe_n = 1'b1;
          next_state = RDONE;
        end
      end
      RDONE:
      begin
        // selects just rose; give the ram its recovery gap
        next_cnt = dpc_pkg::CNT_W'(dpc_pkg::FLAG_GAP_CYC);
        next_state = GAP;
      end
      GAP:
      begin
        // hold time after write end, then release the bus
        next_doe = 1'b0;
        if (cnt > dpc_pkg::CNT_W'(1))
          next_cnt = cnt - dpc_pkg::CNT_W'(1);
        else
        begin
          // lanes rise last so the next address may move
          next_lanes_n = 2'h3;
          next_state = IDLE;
        end
      end
      default:
        next_state = IDLE;
    endcase
  end

  // ****************************************************
  // registers
  // ****************************************************
  // sync reset only; pins come up with all selects high
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      state <= IDLE;
      cnt <= '0;
      is_wr <= 1'b0;
      is_flag <= 1'b0;
      cs_n <= 1'b1;
      fs_n <= 1'b1;
      rw_n <= 1'b1;
      oe_n <= 1'b1;
      lanes_n <= 2'h3;
      addr <= '0;
      wdata <= '0;
      rdata <= '0;
      doe <= 1'b0;
      rsp <= 1'b0;
      coll_seen <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      is_wr <= next_is_wr;
      is_flag <= next_is_flag;
      cs_n <= next_cs_n;
      fs_n <= next_fs_n;
      rw_n <= next_rw_n;
      oe_n <= next_oe_n;
      lanes_n <= next_lanes_n;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      doe <= next_doe;
      rsp <= next_rsp;
      coll_seen <= next_coll_seen;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // the ram grants a contended flag to one port; software rereads it
  assign REQ_READY = (state == IDLE);
  assign RSP_VALID = rsp;
  assign RSP_RDATA = rdata;
  assign CHIP_SEL_N = cs_n;
  assign FLAG_SELECT_N = fs_n;
  assign RW_N = rw_n;
  assign OUT_EN_N = oe_n;
  assign HIGH_LANE_SEL_N = lanes_n[1];
  assign LOW_LANE_SEL_N = lanes_n[0];
  assign ADDR = addr;
  assign DATA_O = wdata;
  assign DATA_OE = doe;
endmodule

// ===== verification/dpc_host_asserts.sv
// Purpose: pin timing checks for dpc_host
// Assumes: one clock, sync reset
// Notes: pins sampled at REF_CLK
`timescale 1ns/1ns
module dpc_host_chk
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CHIP_SEL_N,
  input wire logic FLAG_SELECT_N,
  input wire logic RW_N,
  input wire logic OUT_EN_N,
  input wire logic RSP_VALID,
  input wire logic DATA_OE,
  input wire logic [dpc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [dpc_pkg::DATA_W-1:0] DATA_O
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  property p_sel; !(!CHIP_SEL_N && !FLAG_SELECT_N); endproperty
  a_sel: assert property (p_sel) else $error("both selects low");
  property p_hold_sel; !RW_N && !$past(RW_N) |-> $stable({CHIP_SEL_N, FLAG_SELECT_N}); endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("select moved in write");
  property p_addr; $changed(ADDR) |-> RW_N && $past(RW_N); endproperty
  a_addr: assert property (p_addr) else $error("address moved in write");
  property p_pulse; $fell(RW_N) |-> !RW_N ##1 !RW_N; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse short");
  property p_oe; !RW_N |-> OUT_EN_N; endproperty
  a_oe: assert property (p_oe) else $error("output enable in write");
  property p_flag; $fell(FLAG_SELECT_N) |-> !FLAG_SELECT_N ##1 !FLAG_SELECT_N; endproperty
  a_flag: assert property (p_flag) else $error("flag pulse short");
  property p_setup; $rose(RW_N) |-> $past(DATA_OE, 2); endproperty
  a_setup: assert property (p_setup) else $error("data setup short");
  property p_dhold; $rose(RW_N) |-> DATA_OE && $stable(DATA_O); endproperty
  a_dhold: assert property (p_dhold) else $error("data not held");
  c_write: cover property ($fell(RW_N));
  c_flag: cover property ($fell(FLAG_SELECT_N));
  c_read: cover property (RSP_VALID);
endmodule

// ===== verification/dpc_ram_model.sv
// Purpose: behavioural model of one RAM port
// Assumes: pins sampled on the host clock
// Notes: access slower than the max figures
`timescale 1ns/1ns
module dpc_ram_model
(
  input wire logic clk,
  input wire logic cs_n,
  input wire logic fs_n,
  input wire logic rw_n,
  input wire logic oe_n,
  input wire logic hi_n,
  input wire logic lo_n,
  input wire logic coll_n,
  input wire logic [dpc_pkg::ADDR_W-1:0] addr,
  input wire logic [dpc_pkg::DATA_W-1:0] wdata,
  output logic [dpc_pkg::DATA_W-1:0] rdata
);
  logic [dpc_pkg::DATA_W-1:0] mem [0:16383];
  logic [dpc_pkg::DATA_W-1:0] last;
  logic [7:0] flag;
  logic [2:0] cnt;
  always_ff @(posedge clk)
  begin
    // any break restarts the access time
    if ((cs_n && fs_n) || oe_n || !rw_n || !coll_n)
      cnt <= 3'h0;
    else if (cnt != 3'h7)
      cnt <= cnt + 3'h1;
    if (!cs_n && !rw_n && !hi_n)
      mem[addr][15:8] <= wdata[15:8];
    if (!cs_n && !rw_n && !lo_n)
      mem[addr][7:0] <= wdata[7:0];
    // one port only, so a contended flag always lands here
    if (!fs_n && !rw_n)
      flag[addr[2:0]] <= wdata[0];
    last <= rdata;
  end
  // inverted last-cycle value; it toggles, so early sampling shows the old word or its inverse
  assign rdata = (cnt >= (fs_n ? 3'h3 : 3'h4))
    ? (fs_n ? mem[addr] : {16{flag[addr[2:0]]}}) : ~last;
endmodule

// ===== verification/test_dual_port_ram_port_access.sv
// Purpose: self-checking bench for dpc_host
// Assumes: RAM model on the pins
// Notes: bench drives 1 ns after each edge
`timescale 1ns/1ns
module test_dual_port_ram_port_access;
  logic REF_CLK = 1'b0, RST_N = 1'b0, REQ_VALID = 1'b0, REQ_WRITE = 1'b0;
  logic REQ_FLAG = 1'b0, COLLISION_N = 1'b1, REQ_READY, RSP_VALID, CHIP_SEL_N;
  logic FLAG_SELECT_N, RW_N, OUT_EN_N, HIGH_LANE_SEL_N, LOW_LANE_SEL_N, DATA_OE;
  logic [1:0] REQ_LANES = 2'h3;
  logic [dpc_pkg::ADDR_W-1:0] REQ_ADDR = 14'h0000, ADDR;
  logic [dpc_pkg::DATA_W-1:0] REQ_WDATA = 16'h0000, DATA_I, DATA_O, RSP_RDATA, rd;
  int fails = 0, checks_done = 0, lat;
  always #5 REF_CLK = ~REF_CLK;
  dpc_host uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_FLAG(REQ_FLAG), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_LANES(REQ_LANES), .COLLISION_N(COLLISION_N),
    .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .CHIP_SEL_N(CHIP_SEL_N),
    .FLAG_SELECT_N(FLAG_SELECT_N), .RW_N(RW_N), .OUT_EN_N(OUT_EN_N),
    .HIGH_LANE_SEL_N(HIGH_LANE_SEL_N), .LOW_LANE_SEL_N(LOW_LANE_SEL_N), .ADDR(ADDR),
    .DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE(DATA_OE));
  dpc_ram_model ram (.clk(REF_CLK), .cs_n(CHIP_SEL_N), .fs_n(FLAG_SELECT_N), .rw_n(RW_N),
    .oe_n(OUT_EN_N), .hi_n(HIGH_LANE_SEL_N), .lo_n(LOW_LANE_SEL_N), .coll_n(COLLISION_N),
    .addr(ADDR), .wdata(DATA_O), .rdata(DATA_I));
  task automatic test_done();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded step: a hang ends the run
  task automatic step(inout int n);
    @(posedge REF_CLK);
    #1;
    n++;
    if (n > 30)
    begin
      fails++;
      test_done();
    end
  endtask
  task automatic req(input logic w, f, input logic [13:0] a, input logic [15:0] d,
    input logic [1:0] l);
    int n;
    n = 0;
    while (REQ_READY !== 1'b1)
      step(n);
    {REQ_VALID, REQ_WRITE, REQ_FLAG, REQ_ADDR, REQ_WDATA, REQ_LANES} = {1'b1, w, f, a, d, l};
    step(n);
    REQ_VALID = 1'b0;
    lat = 0;
    while (!w && RSP_VALID !== 1'b1)
      step(lat);
    rd = RSP_RDATA;
  endtask
  task automatic t_array();
    req(1'b1, 1'b0, 14'h0005, 16'ha55a, 2'h3);
    req(1'b1, 1'b0, 14'h3fff, 16'h0f0f, 2'h3);
    req(1'b0, 1'b0, 14'h0005, 16'h0000, 2'h3);
    chk(rd, 16'ha55a);
    chk(16'(lat), 16'(1 + dpc_pkg::ARRAY_READ_CYC));
    req(1'b0, 1'b0, 14'h3fff, 16'h0000, 2'h3);
    chk(rd, 16'h0f0f);
  endtask
  task automatic t_lanes();
    req(1'b1, 1'b0, 14'h0005, 16'h1234, 2'h1);
    req(1'b1, 1'b0, 14'h0005, 16'hffff, 2'h0);
    req(1'b0, 1'b0, 14'h0005, 16'h0000, 2'h3);
    chk(rd, 16'ha534);
    req(1'b1, 1'b0, 14'h0005, 16'h5678, 2'h2);
    req(1'b0, 1'b0, 14'h0005, 16'h0000, 2'h3);
    chk(rd, 16'h5634);
  endtask
  task automatic t_flag();
    req(1'b1, 1'b1, 14'h0003, 16'h0001, 2'h3);
    req(1'b0, 1'b1, 14'h0003, 16'h0000, 2'h3);
    chk(rd, 16'hffff);
    chk(16'(lat), 16'(1 + dpc_pkg::FLAG_READ_CYC));
    req(1'b1, 1'b1, 14'h0003, 16'h0000, 2'h3);
    req(1'b0, 1'b1, 14'h0003, 16'h0000, 2'h3);
    chk(rd, 16'h0000);
  endtask
  task automatic t_coll();
    fork
      req(1'b0, 1'b0, 14'h0005, 16'h0000, 2'h3);
      begin
        repeat (3) @(posedge REF_CLK);
        #1 COLLISION_N = 1'b0;
        repeat (2) @(posedge REF_CLK);
        #1 COLLISION_N = 1'b1;
      end
    join
    chk(rd, 16'h5634);
    chk(16'(lat), 16'(2 + dpc_pkg::COLL_READ_CYC));
  endtask
  initial
  begin
    repeat (16) @(posedge REF_CLK);
    #1 RST_N = 1'b1;
    chk(16'({REQ_READY, CHIP_SEL_N, FLAG_SELECT_N, RW_N, DATA_OE}), 16'h001e);
    t_array();
    t_lanes();
    t_flag();
    t_coll();
    test_done();
  end
endmodule
bind dpc_host dpc_host_chk u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .CHIP_SEL_N(CHIP_SEL_N),
  .FLAG_SELECT_N(FLAG_SELECT_N), .RW_N(RW_N), .OUT_EN_N(OUT_EN_N), .RSP_VALID(RSP_VALID),
  .DATA_OE(DATA_OE), .ADDR(ADDR), .DATA_O(DATA_O));
